// >>> shared/twr_pkg.sv
package twr_pkg;
	// Opcode fields: 1010 11ti ffff ffff (write), 1010 10ti ffff ffff (read)
	localparam logic [5:0] TWR_OP_WRITE = 6'h2b;
	localparam logic [5:0] TWR_OP_READ = 6'h2a;
	localparam int TWR_OP_MSB = 15;
	localparam int TWR_OP_LSB = 10;
	localparam int TWR_T_BIT = 9;
	localparam int TWR_I_BIT = 8;
	localparam logic [15:0] TWR_LATCH_RST = 16'h0000;
	localparam logic [15:0] TWR_PTR_RST = 16'h0000;
	localparam int TWR_EXT_CYCLES = 2;

	typedef struct packed {
		logic valid;
		logic [15:0] word;
	} twr_instr_t;

	typedef struct packed {
		logic req;
		logic write;
		logic internal;
		logic [15:0] addr;
		logic [15:0] wdata;
	} twr_mem_req_t;
endpackage : twr_pkg

// >>> sim/tb.sv
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import twr_pkg::*;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic mem_is_internal = 1'b0;
	logic irq = 1'b0;
	logic prog_voltage_ok = 1'b1;
	logic abort_seen = 1'b0;
	logic status_bad = 1'b0;
	twr_instr_t instr = '0;
	twr_mem_req_t mem_r;
	logic busy_r, done_r, file_we_r, prog_done, prog_abort_r, status_we_r;
	logic [7:0] file_addr_r, file_wdata_r, file_rdata;
	logic [15:0] mem_rdata, table_latch_r, table_pointer_r;
	logic [15:0] prog_delay = 16'h0014;
	logic [7:0] fregs [256];
	int errors = 0;
	int total_checks = 0;
	int cycles = 0;
	int cyc;
	twr_unit dut_u (
		.clock(clock),
		.rst_n(rst_n),
		.instr(instr),
		.busy_r(busy_r),
		.done_r(done_r),
		.file_rdata(file_rdata),
		.file_addr_r(file_addr_r),
		.file_we_r(file_we_r),
		.file_wdata_r(file_wdata_r),
		.mem_rdata(mem_rdata),
		.mem_is_internal(mem_is_internal),
		.prog_done(prog_done),
		.mem_r(mem_r),
		.prog_abort_r(prog_abort_r),
		.irq(irq),
		.prog_voltage_ok(prog_voltage_ok),
		.status_we_r(status_we_r),
		.table_latch_r(table_latch_r),
		.table_pointer_r(table_pointer_r)
	);
	twr_mem_model mem_u (.clock(clock), .rst_n(rst_n), .mem(mem_r),
		.prog_abort(prog_abort_r), .prog_delay(prog_delay),
		.mem_rdata(mem_rdata), .prog_done(prog_done));
	assign file_rdata = fregs[file_addr_r];
	initial
		forever #2 clock = ~clock;
	always @(posedge clock)
	begin
		cycles++;
		if (file_we_r === 1'b1)
			fregs[file_addr_r] <= file_wdata_r;
		if (prog_abort_r === 1'b1)
			abort_seen <= 1'b1;
		if (rst_n && status_we_r !== 1'b0)
			status_bad <= 1'b1;
		if (cycles == 5000)
		begin
			errors++;
			test_done();
		end
	end
	task automatic chk(input string nm, input logic [15:0] exp,
		input logic [15:0] got);
		total_checks++;
		if (got !== exp)
		begin
			errors++;
			$display("FAIL %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic issue(input logic [15:0] w, input logic intl);
		int n;
		n = 0;
		instr = '{valid: 1'b1, word: w};
		mem_is_internal = intl;
		while (busy_r !== 1'b1 && n < 20)
		begin
			@(posedge clock);
			#1;
			n++;
		end
		instr.valid = 1'b0;
		cyc = 0;
		while (done_r !== 1'b1 && cyc < 400)
		begin
			@(posedge clock);
			#1;
			cyc++;
		end
		chk("done", 1'b1, done_r);
		repeat (4) @(posedge clock);
		#1;
	endtask : issue
	task automatic state(input logic [15:0] lat, input logic [15:0] ptr);
		chk("latch", lat, table_latch_r);
		chk("pointer", ptr, table_pointer_r);
	endtask : state
	task automatic t_refuse;
		instr = '{valid: 1'b1, word: 16'ha412};
		repeat (12) @(posedge clock);
		#1;
		chk("busy", 1'b0, busy_r);
		instr.valid = 1'b0;
		// Let an edge pass so the next issue does not drive instr again now
		@(posedge clock);
		#1;
		state(16'h0000, 16'h0000);
		$display("test refuse done");
	endtask : t_refuse
	task automatic t_ext_write;
		issue(16'hae10, 1'b0);
		state(16'h5300, 16'h0000);
		chk("mem0", 16'h5300, mem_u.word_r[0]);
		issue(16'had11, 1'b0);
		// Two instruction cycles of four clocks, busy seen one clock late
		chk("len", 16'h0007, 16'(cyc));
		state(16'h5355, 16'h0001);
		chk("mem0", 16'h5355, mem_u.word_r[0]);
		$display("test external write done");
	endtask : t_ext_write
	task automatic t_int_write;
		prog_voltage_ok = 1'b0;
		issue(16'had12, 1'b1);
		chk("long", 1'b1, cyc > 20);
		state(16'h5377, 16'h0002);
		chk("mem1", 16'h5377, mem_u.word_r[1]);
		prog_delay = 16'hfff0;
		fork
			issue(16'hae13, 1'b1);
			begin
				repeat (10) @(posedge clock);
				#1;
				irq = 1'b1;
			end
		join
		irq = 1'b0;
		chk("abort", 1'b1, abort_seen);
		state(16'h6677, 16'h0002);
		chk("mem2", 16'h1232, mem_u.word_r[2]);
		$display("test eprom write done");
	endtask : t_int_write
	task automatic t_read;
		issue(16'hab20, 1'b0);
		chk("freg20", 16'h0066, {8'h00, fregs[8'h20]});
		state(16'h1232, 16'h0003);
		issue(16'ha821, 1'b0);
		chk("freg21", 16'h0032, {8'h00, fregs[8'h21]});
		state(16'h1233, 16'h0003);
		chk("status", 1'b0, status_bad);
		$display("test read done");
	endtask : t_read
	task automatic test_done;
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : test_done
	initial
	begin
		for (int k = 0; k < 256; k++)
			fregs[k] = 8'(k);
		fregs[8'h10] = 8'h53;
		fregs[8'h11] = 8'h55;
		fregs[8'h12] = 8'h77;
		fregs[8'h13] = 8'h66;
		repeat (12) @(posedge clock);
		#1;
		rst_n = 1'b1;
		t_refuse();
		t_ext_write();
		t_int_write();
		t_read();
		test_done();
	end
endmodule : tb

// >>> sim/twr_mem_model.sv
// Program memory seen from the core: 16 words, external or EPROM
module twr_mem_model
	import twr_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Request side
	input twr_pkg::twr_mem_req_t mem,
	input wire logic prog_abort,
	input wire logic [15:0] prog_delay,
	// Answers
	output logic [15:0] mem_rdata,
	output logic prog_done = 1'b0
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] word_r [16];
	logic [15:0] cnt_r = 16'h0000;
	logic alt_r = 1'b0;
	// Idle bus toggles so a stale word can never look valid
	assign mem_rdata = (mem.req && !mem.write) ? word_r[mem.addr[3:0]]
		: (alt_r ? 16'ha5a5 : 16'h5a5a);
	initial
	begin
		for (int k = 0; k < 16; k++)
			word_r[k] = 16'h1230 + 16'(k);
	end
	always @(posedge clock)
	begin
		alt_r <= ~alt_r;
		prog_done <= 1'b0;
		if (!rst_n || !mem.req || prog_abort)
			cnt_r <= 16'h0000;
		else if (mem.write && !mem.internal)
			word_r[mem.addr[3:0]] <= mem.wdata;
		else if (mem.write && cnt_r != 16'hffff)
		begin
			cnt_r <= cnt_r + 16'h0001;
			if (cnt_r == prog_delay)
			begin
				word_r[mem.addr[3:0]] <= mem.wdata;
				prog_done <= 1'b1;
				cnt_r <= 16'hffff;
			end
		end
	end
endmodule : twr_mem_model

// >>> src/twr_qgen.sv
// Quarter-phase generator: one-cycle enable per phase, Q1..Q4 in turn
module twr_qgen
	import twr_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Phase enables
	output logic [3:0] q_r
);
	always_ff @(posedge clock)
	begin
		if (!rst_n)
			q_r <= 4'h1;
		else
			q_r <= {q_r[2:0], q_r[3]};
	end
endmodule : twr_qgen

// >>> src/twr_unit.sv
// Overview of operation
// - Decode the table write word 1010 11ti ffff ffff into t, i and f.
// - First copy file register f into one half of the table latch.
// - t=0 replaces the low latch byte, t=1 the high, the other is kept.
// - Then write the whole latch to program memory at the table pointer.
// - With i=1 the pointer increments after the write, else it stays.
// - A write to external memory completes in exactly two cycles.
// - A write to on-chip EPROM lasts until programming reports done.
// - An interrupt during an EPROM write aborts it and ends the op.
// - Programming runs even when the programming pin is at supply only.
// - Table read moves a latch byte to f, reloads latch, may increment.
module twr_unit
	import twr_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Instruction issue
	input twr_pkg::twr_instr_t instr,
	output logic busy_r,
	output logic done_r,
	// File register access
	input wire logic [7:0] file_rdata,
	output logic [7:0] file_addr_r,
	output logic file_we_r,
	output logic [7:0] file_wdata_r,
	// Program memory
	input wire logic [15:0] mem_rdata,
	input wire logic mem_is_internal,
	input wire logic prog_done,
	output twr_pkg::twr_mem_req_t mem_r,
	output logic prog_abort_r,
	// Interrupt and programming voltage level
	input wire logic irq,
	input wire logic prog_voltage_ok,
	// Status flag write enable (kept low)
	output logic status_we_r,
	// Visible state
	output logic [15:0] table_latch_r,
	output logic [15:0] table_pointer_r
);
	typedef enum logic [4:0] {
		TWR_IDLE = 5'h01,
		TWR_EXT = 5'h02,
		TWR_PROG = 5'h04,
		TWR_RD = 5'h08,
		TWR_END = 5'h10
	} twr_state_t;

	twr_state_t state_r;
	logic [3:0] q;
	logic t_r;
	logic inc_r;
	logic is_wr;
	logic is_rd;
	logic [1:0] cyc_r;
	logic load_r;

	twr_qgen u_qgen (
		.clock(clock),
		.rst_n(rst_n),
		.q_r(q)
	);

	function automatic logic op_is(input logic [15:0] w,
		input logic [5:0] op);
		op_is = (w[TWR_OP_MSB:TWR_OP_LSB] == op);
	endfunction : op_is

	assign is_wr = instr.valid && op_is(instr.word, TWR_OP_WRITE);
	assign is_rd = instr.valid && op_is(instr.word, TWR_OP_READ);

	// Sequencing; instructions are taken at Q1 only
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			state_r <= TWR_IDLE;
			t_r <= 1'b0;
			inc_r <= 1'b0;
			cyc_r <= 2'h0;
			load_r <= 1'b0;
		end
		else
		begin
			load_r <= 1'b0;
			case (state_r)
				TWR_IDLE:
				begin
					if (q[0] && (is_wr || is_rd))
					begin
						t_r <= instr.word[TWR_T_BIT];
						inc_r <= instr.word[TWR_I_BIT];
						load_r <= 1'b1;
						cyc_r <= 2'h0;
						state_r <= is_wr ? (mem_is_internal ? TWR_PROG : TWR_EXT)
							: TWR_RD;
					end
				end
				TWR_EXT, TWR_RD:
				begin
					// Two instruction cycles, counted on Q4 edges
					if (q[3])
					begin
						cyc_r <= cyc_r + 2'h1;
						if (cyc_r == 2'(TWR_EXT_CYCLES - 1))
							state_r <= TWR_END;
					end
				end
				TWR_PROG:
				begin
					// Pin level is not checked: the sequence runs anyway
					if (prog_done || irq)
						state_r <= TWR_END;
				end
				TWR_END:
					state_r <= TWR_IDLE;
				default:
					state_r <= TWR_IDLE;
			endcase
		end
	end

	// File register port: address at issue, read writes f in Q4
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			file_addr_r <= 8'h00;
			file_we_r <= 1'b0;
			file_wdata_r <= 8'h00;
		end
		else
		begin
			file_we_r <= 1'b0;
			if (state_r == TWR_IDLE && q[0] && (is_wr || is_rd))
				file_addr_r <= instr.word[7:0];
			if (state_r == TWR_RD && q[3] && cyc_r == 2'h0)
			begin
				file_we_r <= 1'b1;
				file_wdata_r <= t_r ? table_latch_r[15:8] : table_latch_r[7:0];
			end
		end
	end

	// Table latch
	always_ff @(posedge clock)
	begin
		if (!rst_n)
			table_latch_r <= TWR_LATCH_RST;
		else if (load_r && state_r != TWR_RD)
		begin
			if (t_r)
				table_latch_r[15:8] <= file_rdata;
			else
				table_latch_r[7:0] <= file_rdata;
		end
		else if (state_r == TWR_RD && q[3] && cyc_r == 2'h1)
			table_latch_r <= mem_rdata;
	end

	// Memory request and pointer
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			mem_r <= '0;
			table_pointer_r <= TWR_PTR_RST;
			prog_abort_r <= 1'b0;
		end
		else
		begin
			prog_abort_r <= 1'b0;
			if (state_r == TWR_PROG && irq && !prog_done)
				prog_abort_r <= 1'b1;
			if ((state_r == TWR_EXT || state_r == TWR_PROG) && !load_r
				&& !mem_r.req && state_r != TWR_END && cyc_r == 2'h0
				&& !(state_r == TWR_PROG && (prog_done || irq)))
			begin
				mem_r.req <= 1'b1;
				mem_r.write <= 1'b1;
				mem_r.internal <= (state_r == TWR_PROG);
				mem_r.addr <= table_pointer_r;
				mem_r.wdata <= table_latch_r;
			end
			else if (state_r == TWR_RD && !load_r && !mem_r.req
				&& cyc_r == 2'h0)
			begin
				mem_r.req <= 1'b1;
				mem_r.write <= 1'b0;
				mem_r.internal <= mem_is_internal;
				mem_r.addr <= table_pointer_r;
			end
			if (state_r == TWR_END)
			begin
				mem_r.req <= 1'b0;
				if (inc_r)
					table_pointer_r <= table_pointer_r + 16'h0001;
			end
		end
	end

	// Handshake and status flags
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			busy_r <= 1'b0;
			done_r <= 1'b0;
			status_we_r <= 1'b0;
		end
		else
		begin
			busy_r <= (state_r != TWR_IDLE && state_r != TWR_END);
			done_r <= (state_r == TWR_END);
			status_we_r <= 1'b0;
		end
	end

	a_ptr_hold: assert property (@(posedge clock) disable iff (!rst_n)
		(state_r == TWR_END && !inc_r) |=> $stable(table_pointer_r))
		else $error("pointer moved without increment");
	a_ptr_inc: assert property (@(posedge clock) disable iff (!rst_n)
		(state_r == TWR_END && inc_r)
		|=> table_pointer_r == $past(table_pointer_r) + 16'h0001)
		else $error("pointer not incremented");
	a_ext_len: assert property (@(posedge clock) disable iff (!rst_n)
		(state_r == TWR_IDLE && $past(state_r) == TWR_IDLE) ##1
		(state_r == TWR_EXT) |-> ##[5:9] state_r == TWR_END)
		else $error("external write length wrong");
	a_irq_abort: assert property (@(posedge clock) disable iff (!rst_n)
		(state_r == TWR_PROG && irq) |=> state_r == TWR_END)
		else $error("interrupt did not end write");
	a_prog_wait: assert property (@(posedge clock) disable iff (!rst_n)
		(state_r == TWR_PROG && !irq && !prog_done) |=> state_r == TWR_PROG)
		else $error("EPROM write ended early");
	a_latch_half: assert property (@(posedge clock) disable iff (!rst_n)
		(load_r && state_r != TWR_RD && t_r)
		|=> table_latch_r[7:0] == $past(table_latch_r[7:0])
		&& table_latch_r[15:8] == $past(file_rdata))
		else $error("latch high load wrong");
	a_latch_low: assert property (@(posedge clock) disable iff (!rst_n)
		(load_r && state_r != TWR_RD && !t_r)
		|=> table_latch_r[15:8] == $past(table_latch_r[15:8])
		&& table_latch_r[7:0] == $past(file_rdata))
		else $error("latch low load wrong");
	a_wdata_latch: assert property (@(posedge clock) disable iff (!rst_n)
		$rose(mem_r.req) && mem_r.write
		|-> mem_r.wdata == table_latch_r && mem_r.addr == table_pointer_r)
		else $error("write word not latch at pointer");
	a_no_status: assert property (@(posedge clock) disable iff (!rst_n)
		busy_r |-> !status_we_r)
		else $error("status written");
	a_rd_file: assert property (@(posedge clock) disable iff (!rst_n)
		file_we_r |-> file_wdata_r == (t_r ? $past(table_latch_r[15:8])
		: $past(table_latch_r[7:0])))
		else $error("read byte wrong");
endmodule : twr_unit
